// file: hw/iosw_top.sv
// internal oscillator select and glitch-free switch with axi4-lite registers
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module iosw_top (
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration word fields
  input wire logic [1:0] cfg_fosc,
  input wire logic cfg_pll_enable,
  // oscillator clock levels from the analog block, index lf/mf/hf
  input wire logic [2:0] osc_level,
  input wire logic pll_lock,
  // outputs to the clock tree
  output logic [2:0] osc_enable,
  output logic pll_enable,
  output logic pll_32m_active,
  output logic [3:0] sys_freq_sel,
  output logic [5:0] osc_trim_value,
  output logic sys_clk_out,
  output logic switch_busy
);

  // two-flop synchronisers for the asynchronous oscillator and lock levels
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  // edges are judged on the settled second stage only
  logic [2:0] lvl_prev;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      lvl_prev <= 3'h0;
    end else begin
      sync_a <= {pll_lock, osc_level};
      sync_b <= sync_a;
      lvl_prev <= sync_b[2:0];
    end
  end

  logic [2:0] lvl;
  logic lock_s;
  assign lvl = sync_b[2:0];
  assign lock_s = sync_b[3];

  // map a frequency select code onto its oscillator
  function automatic logic [1:0] src_of(input logic [3:0] f);
    if (f[3]) begin
      src_of = 2'(iosw_pkg::OSC_HF);
    end else if (f <= iosw_pkg::FSEL_LF_TOP) begin
      src_of = 2'(iosw_pkg::OSC_LF);
    end else begin
      src_of = 2'(iosw_pkg::OSC_MF);
    end
  endfunction

  // register and switch state
  iosw_pkg::iosw_ctrl_s ctrl, next_ctrl;
  logic [5:0] trim, next_trim;
  iosw_pkg::iosw_state_e state, next_state;
  logic [1:0] cur_src, next_cur_src;
  logic [1:0] tgt_src, next_tgt_src;
  logic [3:0] cur_fsel, next_cur_fsel;
  logic [3:0] tgt_fsel, next_tgt_fsel;
  logic [9:0] su_cnt, next_su_cnt;
  logic [2:0] osc_on, next_osc_on;
  logic [2:0] osc_run, next_osc_run;
  logic clk_q, next_clk_q;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;

  // bus handshakes: write taken with address and data together
  logic wr_go;
  logic rd_go;
  logic fsel_wr;
  logic [3:0] new_fsel;
  logic [1:0] new_src;
  logic pll_on;
  iosw_pkg::iosw_stat_s stat;
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid;
  assign rd_go = s_axi_arvalid & ~rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // pll enable: software bit or locked on by configuration
  assign pll_on = ctrl.sw_pll_enable | cfg_pll_enable;

  // status word from live oscillator state
  always_comb begin
    stat = '0;
    stat.pll_ready_flag = lock_s & pll_on;
    stat.osc_startup_status = (cfg_fosc == iosw_pkg::FOSC_INTERNAL_OSC_SOURCE);
    stat.high_freq_ready_flag = osc_run[iosw_pkg::OSC_HF];
    stat.high_freq_locked_flag = osc_run[iosw_pkg::OSC_HF] & (state == iosw_pkg::IOSW_IDLE);
    stat.mid_freq_ready_flag = osc_run[iosw_pkg::OSC_MF];
    stat.low_freq_ready_flag = osc_run[iosw_pkg::OSC_LF];
    stat.high_freq_stable_flag = stat.high_freq_locked_flag;
  end

  // register writes and reads
  always_comb begin
    next_ctrl = ctrl;
    next_trim = trim;
    next_bvalid = bvalid & ~s_axi_bready;
    next_bresp = bresp;
    next_rvalid = rvalid & ~s_axi_rready;
    next_rresp = rresp;
    next_rdata = rdata;
    fsel_wr = 1'b0;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = iosw_pkg::AXI_OKAY;
      if (s_axi_awaddr == iosw_pkg::OSC_CONTROL_OFS) begin
        if (s_axi_wstrb[0]) begin
          next_ctrl = iosw_pkg::iosw_ctrl_s'(s_axi_wdata[7:0]);
          next_ctrl.unused_bit2 = 1'b0;
          fsel_wr = 1'b1;
        end
      end else if (s_axi_awaddr == iosw_pkg::OSC_TUNING_OFS) begin
        if (s_axi_wstrb[0]) begin
          next_trim = s_axi_wdata[5:0];
        end
      end else if (s_axi_awaddr != iosw_pkg::OSC_STATUS_OFS) begin
        next_bresp = iosw_pkg::AXI_SLVERR;
      end
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = iosw_pkg::AXI_OKAY;
      next_rdata = '0;
      case (s_axi_araddr)
        iosw_pkg::OSC_CONTROL_OFS: begin
          next_rdata[7:0] = ctrl;
          next_rdata[7] = pll_on;
        end
        iosw_pkg::OSC_STATUS_OFS: begin
          next_rdata[7:0] = stat;
        end
        iosw_pkg::OSC_TUNING_OFS: begin
          next_rdata[5:0] = trim;
        end
        default: begin
          next_rresp = iosw_pkg::AXI_SLVERR;
        end
      endcase
    end
  end

  // incoming select, decoded to its oscillator
  assign new_fsel = next_ctrl.int_osc_freq_select;
  assign new_src = src_of(new_fsel);

  // switch sequence: start-up, wait fall of old, hold low, wait rise of new
  always_comb begin
    next_state = state;
    next_cur_src = cur_src;
    next_tgt_src = tgt_src;
    next_cur_fsel = cur_fsel;
    next_tgt_fsel = tgt_fsel;
    next_su_cnt = su_cnt;
    next_osc_on = osc_on;
    next_osc_run = osc_run;
    next_clk_q = clk_q;
    case (state)
      iosw_pkg::IOSW_IDLE: begin
        next_clk_q = lvl[cur_src];
      end
      iosw_pkg::IOSW_STARTUP: begin
        next_clk_q = lvl[cur_src];
        if (su_cnt == 10'h001) begin
          next_osc_run[tgt_src] = 1'b1;
          next_state = iosw_pkg::IOSW_WAIT_FALL;
        end else begin
          next_su_cnt = su_cnt - 10'h001;
        end
      end
      iosw_pkg::IOSW_WAIT_FALL: begin
        next_clk_q = lvl[cur_src];
        if (lvl_prev[cur_src] & ~lvl[cur_src]) begin
          next_clk_q = 1'b0;
          next_state = iosw_pkg::IOSW_WAIT_RISE;
        end
      end
      iosw_pkg::IOSW_WAIT_RISE: begin
        next_clk_q = 1'b0;
        if (~lvl_prev[tgt_src] & lvl[tgt_src]) begin
          next_clk_q = 1'b1;
          next_cur_src = tgt_src;
          next_cur_fsel = tgt_fsel;
          next_osc_on = 3'h0;
          next_osc_on[tgt_src] = 1'b1;
          next_osc_run = 3'h0;
          next_osc_run[tgt_src] = 1'b1;
          next_state = iosw_pkg::IOSW_IDLE;
        end
      end
      default: begin
        next_state = iosw_pkg::IOSW_IDLE;
      end
    endcase
    // a new select restarts the sequence from the live clock
    if (fsel_wr) begin
      next_tgt_fsel = new_fsel;
      if (new_src == cur_src) begin
        next_cur_fsel = new_fsel;
        next_tgt_src = cur_src;
        next_clk_q = lvl[cur_src];
        next_state = iosw_pkg::IOSW_IDLE;
      end else begin
        next_tgt_src = new_src;
        next_osc_on[new_src] = 1'b1;
        if (osc_run[new_src]) begin
          next_clk_q = lvl[cur_src];
          next_state = iosw_pkg::IOSW_WAIT_FALL;
        end else begin
          next_su_cnt = iosw_pkg::STARTUP_CYC;
          next_clk_q = lvl[cur_src];
          next_state = iosw_pkg::IOSW_STARTUP;
        end
      end
    end
    // the high oscillator must stay powered while it feeds the pll
    if (pll_on) begin
      next_osc_on[iosw_pkg::OSC_HF] = next_osc_on[iosw_pkg::OSC_HF]
        | (next_cur_src == 2'(iosw_pkg::OSC_HF));
    end
  end

  // state registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl <= iosw_pkg::iosw_ctrl_s'(iosw_pkg::OSC_CONTROL_RST);
      trim <= iosw_pkg::OSC_TUNING_RST;
      state <= iosw_pkg::IOSW_IDLE;
      cur_src <= 2'(iosw_pkg::OSC_MF);
      tgt_src <= 2'(iosw_pkg::OSC_MF);
      cur_fsel <= iosw_pkg::OSC_CONTROL_RST[6:3];
      tgt_fsel <= iosw_pkg::OSC_CONTROL_RST[6:3];
      su_cnt <= 10'h000;
      osc_on <= 3'h2;
      osc_run <= 3'h2;
      clk_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      trim <= next_trim;
      state <= next_state;
      cur_src <= next_cur_src;
      tgt_src <= next_tgt_src;
      cur_fsel <= next_cur_fsel;
      tgt_fsel <= next_tgt_fsel;
      su_cnt <= next_su_cnt;
      osc_on <= next_osc_on;
      osc_run <= next_osc_run;
      clk_q <= next_clk_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // pll path qualifiers
  logic path_32m, next_path_32m;
  logic pll_q, next_pll_q;
  always_comb begin
    next_pll_q = pll_on;
    next_path_32m = pll_on
      & (cfg_fosc == iosw_pkg::FOSC_INTERNAL_OSC_SOURCE)
      & (ctrl.clk_source_select == iosw_pkg::SRC_FROM_CFG)
      & (cur_fsel == iosw_pkg::FSEL_HF_8M)
      & (cur_src == 2'(iosw_pkg::OSC_HF))
      & (state == iosw_pkg::IOSW_IDLE);
  end

  // register the pll qualifiers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      path_32m <= 1'b0;
      pll_q <= 1'b0;
    end else begin
      path_32m <= next_path_32m;
      pll_q <= next_pll_q;
    end
  end

  // outputs
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign osc_enable = osc_on;
  assign pll_enable = pll_q;
  assign pll_32m_active = path_32m;
  assign sys_freq_sel = cur_fsel;
  assign osc_trim_value = trim;
  assign sys_clk_out = clk_q;
  assign switch_busy = (state != iosw_pkg::IOSW_IDLE);

endmodule
`default_nettype wire

// file: inc/iosw_pkg.sv
// constants and types for the internal oscillator select switch
package iosw_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [3:0] OSC_CONTROL_OFS = 4'h0;
  localparam logic [3:0] OSC_STATUS_OFS = 4'h4;
  localparam logic [3:0] OSC_TUNING_OFS = 4'h8;
  // reset values
  localparam logic [7:0] OSC_CONTROL_RST = 8'h38;
  localparam logic [5:0] OSC_TUNING_RST = 6'h00;
  // field encodings
  localparam logic [1:0] SRC_FROM_CFG = 2'h0;
  localparam logic [1:0] FOSC_INTERNAL_OSC_SOURCE = 2'h0;
  localparam logic [3:0] FSEL_HF_8M = 4'hE;
  localparam logic [3:0] FSEL_LF_TOP = 4'h1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // oscillator index within the enable and level vectors
  localparam int OSC_LF = 0;
  localparam int OSC_MF = 1;
  localparam int OSC_HF = 2;
  localparam int OSC_N = 3;
  // oscillator start-up delay
  localparam int STARTUP_NS = 2000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int STARTUP_CYC_I = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0] STARTUP_CYC = STARTUP_CYC_I[9:0];
  // switch sequence states, gray coded along the path
  typedef enum logic [1:0] {
    IOSW_IDLE = 2'h0,
    IOSW_STARTUP = 2'h1,
    IOSW_WAIT_FALL = 2'h3,
    IOSW_WAIT_RISE = 2'h2
  } iosw_state_e;
  // oscillator control register fields
  typedef struct packed {
    logic sw_pll_enable;
    logic [3:0] int_osc_freq_select;
    logic unused_bit2;
    logic [1:0] clk_source_select;
  } iosw_ctrl_s;
  // oscillator status register fields
  typedef struct packed {
    logic unused_bit7;
    logic pll_ready_flag;
    logic osc_startup_status;
    logic high_freq_ready_flag;
    logic high_freq_locked_flag;
    logic mid_freq_ready_flag;
    logic low_freq_ready_flag;
    logic high_freq_stable_flag;
  } iosw_stat_s;
endpackage

// file: tb/iosw_props.sv
// assertion checker on the oscillator switch top ports
`timescale 1ns/1ps
`default_nettype none
module iosw_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] cfg_fosc,
  input wire logic cfg_pll_enable,
  input wire logic pll_enable,
  input wire logic pll_32m_active
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // write channel handshake and response
  property p_aw_ready;
    s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid);
  endproperty
  a_aw_ready: assert property (p_aw_ready) else $error("write ready wrong");
  property p_b_after;
    s_axi_awvalid && s_axi_awready |=> s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  // read channel handshake and response
  property p_ar_ready;
    s_axi_arready == (s_axi_arvalid && !s_axi_rvalid);
  endproperty
  a_ar_ready: assert property (p_ar_ready) else $error("read ready wrong");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read response late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  // pll enable and 32 MHz path
  property p_pll_on;
    cfg_pll_enable |=> pll_enable;
  endproperty
  a_pll_on: assert property (p_pll_on) else $error("pll not forced on");
  property p_32m_src;
    pll_32m_active |-> $past(cfg_fosc) == iosw_pkg::FOSC_INTERNAL_OSC_SOURCE;
  endproperty
  a_32m_src: assert property (p_32m_src) else $error("32 MHz on wrong source");
endmodule
`default_nettype wire

// file: tb/iosw_bench.sv
// self-checking bench for the oscillator select switch
`timescale 1ns/1ps
`default_nettype none
module iosw_bench;
  localparam logic [3:0] CTL_A = iosw_pkg::OSC_CONTROL_OFS;
  localparam logic [3:0] STS_A = iosw_pkg::OSC_STATUS_OFS;
  localparam logic [3:0] TRM_A = iosw_pkg::OSC_TUNING_OFS;
  localparam logic [1:0] OK_R = iosw_pkg::AXI_OKAY;
  localparam int SPAN = iosw_pkg::STARTUP_CYC_I - 2;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, div = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, cfg_pll_enable = 1'b0, pll_lock = 1'b0;
  logic [1:0] cfg_fosc = 2'h0, s_axi_bresp, s_axi_rresp, r;
  logic [2:0] osc_level = 3'h0, osc_enable;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pll_enable;
  logic pll_32m_active, sys_clk_out, switch_busy, c;
  logic [3:0] sys_freq_sel;
  logic [5:0] osc_trim_value;
  int fails = 0, num_checks = 0, n;
  iosw_top u_iosw_top (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .cfg_fosc(cfg_fosc), .cfg_pll_enable(cfg_pll_enable), .osc_level(osc_level),
    .pll_lock(pll_lock), .osc_enable(osc_enable), .pll_enable(pll_enable),
    .pll_32m_active(pll_32m_active), .sys_freq_sel(sys_freq_sel),
    .osc_trim_value(osc_trim_value), .sys_clk_out(sys_clk_out), .switch_busy(switch_busy)
  );
  // clock
  always #2.5 core_clk = ~core_clk;
  // oscillators run only while powered, disabled ones sit low
  always @(posedge core_clk) begin
    div <= div + 4'h1;
    osc_level <= osc_enable & {div[0], div[1], div[3]};
    pll_lock <= pll_enable;
  end
  // compare and count
  task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // bus write with response check
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge core_clk);
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  // bus read into d and r
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge core_clk);
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // count cycles until the switch ends
  task automatic idle_len();
    n = 0;
    while (switch_busy === 1'b1) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  // verdict
  task automatic test_done();
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    test_done();
  end
  // test sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("freq rst", sys_freq_sel, 4'h7);
    chk("osc_en rst", osc_enable, 3'h2);
    chk("clk rst", sys_clk_out, 1'b0);
    rd(CTL_A);
    chk("ctl rst", {r, d}, {OK_R, 24'h0, iosw_pkg::OSC_CONTROL_RST});
    rd(4'hC);
    chk("unmapped rd", {r, d}, {iosw_pkg::AXI_SLVERR, 32'h0});
    wr(4'hC, 32'h1, iosw_pkg::AXI_SLVERR);
    wr(TRM_A, 32'hFF, OK_R);
    rd(TRM_A);
    chk("trim rd", d, 32'h3F);
    chk("trim out", osc_trim_value, 6'h3F);
    wr(STS_A, 32'hFF, OK_R);
    // change within the running mid oscillator
    wr(CTL_A, 32'h28, OK_R);
    @(posedge core_clk);
    chk("same osc freq", sys_freq_sel, 4'h5);
    chk("same osc busy", switch_busy, 1'b0);
    // switch to the stopped high oscillator
    wr(CTL_A, 32'h70, OK_R);
    @(posedge core_clk);
    idle_len();
    chk("startup span", n >= SPAN, 1'b1);
    chk("hf freq", sys_freq_sel, iosw_pkg::FSEL_HF_8M);
    chk("hf osc_en", osc_enable, 3'h4);
    c = sys_clk_out;
    @(posedge core_clk);
    chk("hf clk", sys_clk_out, !c);
    rd(STS_A);
    chk("hf ready", d[4], 1'b1);
    // 32 MHz path conditions
    wr(CTL_A, 32'hF0, OK_R);
    repeat (8) @(posedge core_clk);
    chk("pll sw", pll_enable, 1'b1);
    chk("32m on", pll_32m_active, 1'b1);
    cfg_fosc <= 2'h1;
    repeat (4) @(posedge core_clk);
    chk("32m fosc", pll_32m_active, 1'b0);
    cfg_fosc <= 2'h0;
    wr(CTL_A, 32'hF2, OK_R);
    repeat (4) @(posedge core_clk);
    chk("32m scs", pll_32m_active, 1'b0);
    wr(CTL_A, 32'h70, OK_R);
    repeat (4) @(posedge core_clk);
    chk("pll off", pll_enable, 1'b0);
    cfg_pll_enable <= 1'b1;
    wr(CTL_A, 32'h70, OK_R);
    repeat (8) @(posedge core_clk);
    chk("pll forced", pll_enable, 1'b1);
    chk("32m cfg", pll_32m_active, 1'b1);
    rd(CTL_A);
    chk("ctl pll bit", d[7], 1'b1);
    rd(STS_A);
    chk("pll ready", d[6], 1'b1);
    cfg_pll_enable <= 1'b0;
    // retarget in mid-switch
    wr(CTL_A, 32'h00, OK_R);
    repeat (50) @(posedge core_clk);
    wr(CTL_A, 32'h38, OK_R);
    @(posedge core_clk);
    idle_len();
    chk("restart span", n >= SPAN, 1'b1);
    chk("mf freq", sys_freq_sel, 4'h7);
    chk("mf osc_en", osc_enable, 3'h2);
    test_done();
  end
endmodule
bind iosw_top iosw_props u_iosw_props (
  .core_clk(core_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cfg_fosc(cfg_fosc), .cfg_pll_enable(cfg_pll_enable), .pll_enable(pll_enable),
  .pll_32m_active(pll_32m_active)
);
`default_nettype wire
